/* File: include/scaler_ctrl_pkg.sv */
// Purpose: Shared constants and types for the scaler power, status and task control registers.
// Assumes: Byte-wide subaddressed register access from the serial host interface.
// Notes: Bit positions follow the register layout; reserved bits read as zero.
package scaler_ctrl_pkg;

  // ************************************************************
  // Register subaddresses
  // ************************************************************
  localparam logic [7:0] ADDR_POWER_SAVE = 8'h88; // Power-save control.
  localparam logic [7:0] ADDR_STATUS = 8'h8F; // Read-only scaler status.
  localparam logic [7:0] ADDR_TASK_A = 8'h90; // Task set A handling.
  localparam logic [7:0] ADDR_TASK_B = 8'hC0; // Task set B handling.

  // ************************************************************
  // Power-save field positions
  // ************************************************************
  localparam int PS_SECOND_CH = 7; // Second analog channel enable.
  localparam int PS_FIRST_CH = 6; // First analog channel enable.
  localparam int PS_SOFT_RST = 5; // Scaler soft reset release.
  localparam int PS_MARKER = 4; // Programmed marker.
  localparam int PS_AUDIO_SLEEP = 3; // Audio clock sleep.
  localparam int PS_SCALER_SLEEP = 1; // Scaler sleep.
  localparam int PS_DECODER_SLEEP = 0; // Decoder sleep.
  localparam logic [7:0] PS_WRITE_MASK = 8'hFB; // Bit 2 is reserved.
  localparam logic [7:0] PS_RESET = 8'h00; // Reset value of power-save.

  // ************************************************************
  // Status field positions
  // ************************************************************
  localparam int ST_EXPANSION_TRISTATE_PIN = 7; // Expansion tristate pin level.
  localparam int ST_IMAGE_TRISTATE_PIN = 6; // Image tristate pin level.
  localparam int ST_FIFO_FILL = 5; // FIFO almost filled.
  localparam int ST_FIFO_OVF = 4; // FIFO overflow.
  localparam int ST_ECHO = 3; // Programmed marker echo.
  localparam int ST_FMT_ERR = 2; // Formatter error.
  localparam int ST_IN_FID = 1; // Input field id.
  localparam int ST_OUT_FID = 0; // Output field id.

  // ************************************************************
  // Task handling field positions
  // ************************************************************
  localparam int TK_POLARITY = 7; // Task flag polarity.
  localparam int TK_FID_SEL = 6; // Output field id select.
  localparam int TK_SKIP_HI = 5; // Field skip count, upper bit.
  localparam int TK_SKIP_LO = 3; // Field skip count, lower bit.
  localparam logic [7:0] TK_WRITE_MASK = 8'hF8; // Low bits not held here.
  localparam logic [7:0] TK_RESET = 8'h00; // Reset value of a task set.
  localparam logic [2:0] SKIP_ZERO = 3'h0; // Skip count that starts at once.

  // Live status inputs from the scaler and pins.
  typedef struct packed {
    logic expansion_tristate_pin;
    logic image_tristate_pin;
    logic fifo_almost_filled;
    logic fifo_overflow_flag;
    logic formatter_error;
    logic input_field_id;
  } status_in_t;

  // Power controls sent to the analog and digital blocks.
  typedef struct packed {
    logic first_channel_active;
    logic second_channel_active;
    logic scaler_hold_idle;
    logic decoder_power_down;
    logic scaler_power_down;
    logic scaler_running;
    logic image_port_out_enable;
    logic audio_clock_power_down;
    logic audio_clock_out_enable;
  } power_out_t;

  // Decoded fields of one task register set.
  typedef struct packed {
    logic task_flag_polarity;
    logic output_field_id_select;
    logic [2:0] field_skip_count;
  } task_fields_t;

  // Task sequencer states.
  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_SKIP = 2'b01,
    TS_RUN = 2'b10
  } task_state_t;

endpackage

/* File: rtl/task_reg_set.sv */
// Purpose: One task handling register set holding field select, polarity and skip count.
// Assumes: Writes arrive as single-cycle strobes with byte data.
// Notes: Read data come out of a register; unheld low bits read as zero.
module task_reg_set (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output scaler_ctrl_pkg::task_fields_t fields
);

  // ************************************************************
  // Storage
  // ************************************************************
  // The stored byte is itself the read register, so readback is registered.
  // Independent storage per set.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= scaler_ctrl_pkg::TK_RESET;
    end else if (wr_en) begin
      rd_data <= wr_data & scaler_ctrl_pkg::TK_WRITE_MASK;
    end
  end

  // Field view for the sequencer.
  assign fields.task_flag_polarity = rd_data[scaler_ctrl_pkg::TK_POLARITY];
  assign fields.output_field_id_select = rd_data[scaler_ctrl_pkg::TK_FID_SEL];
  assign fields.field_skip_count = rd_data[scaler_ctrl_pkg::TK_SKIP_HI:scaler_ctrl_pkg::TK_SKIP_LO];

endmodule

/* File: rtl/scaler_power_status_task_ctrl.sv */
// Purpose: Power-save control, live scaler status and task handling control registers.
// Assumes: Host access decoded to subaddress, write strobe and read strobe on clk_sys.
// Notes: Status reads are combinational and unlatched; all other reads are registered values.
//
// How it works
// - Programmed marker clears on every reset.
// - Marker copied into echo status bit.
// - Soft reset bit zero holds scaler idle.
// - Channel enables power channels up or down.
// - Decoder sleep; scaler needs expansion sources.
// - Scaler sleep stops scaler and image output.
// - Audio sleep stops audio clock and output.
// - Status shows live tristate pin levels.
// - Status shows FIFO filled and overflow.
// - Formatter error flags rate conflicts.
// - Status shows input and output field ids.
// - Status reads are live, never latched.
// - Field id select picks input or toggle.
// - Polarity sets code bit and task flag.
// - Skip count fields before task runs.
// - Two independent task sets A and B.
module scaler_power_status_task_ctrl (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire scaler_ctrl_pkg::status_in_t status_in,
  input wire logic scaler_source_is_expansion,
  input wire logic image_clock_is_expansion,
  input wire logic field_start,
  input wire logic task_request,
  input wire logic task_use_set_b,
  output scaler_ctrl_pkg::power_out_t power_out,
  output logic output_field_id,
  output logic code_bit_d7,
  output logic task_flag,
  output logic task_active
);

  // ************************************************************
  // Address decode
  // ************************************************************
  // Decode used by both write and read paths.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  logic [7:0] power_save; // Power-save control register.
  logic [7:0] task_a_rd; // Readback of set A.
  logic [7:0] task_b_rd; // Readback of set B.
  scaler_ctrl_pkg::task_fields_t fields_a; // Fields of set A.
  scaler_ctrl_pkg::task_fields_t fields_b; // Fields of set B.
  scaler_ctrl_pkg::task_fields_t sel; // Fields of the set in use.
  logic [7:0] status_byte; // Live status byte.
  logic next_toggle; // Next value of the activation toggle.
  logic task_toggle; // Toggles on each task activation.
  logic [2:0] skip_left; // Fields still to skip.
  logic using_b; // Set latched at task request.
  scaler_ctrl_pkg::task_state_t state; // Task sequencer state.
  scaler_ctrl_pkg::task_state_t next_state; // Next sequencer state.
  logic scaler_ok; // Scaler path allowed to operate.

  // ************************************************************
  // Power-save register
  // ************************************************************
  // Reset clears every bit, including the programmed marker.
  // Marker cleared at reset.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_save <= scaler_ctrl_pkg::PS_RESET;
    end else if (reg_wr && hit(reg_addr, scaler_ctrl_pkg::ADDR_POWER_SAVE)) begin
      power_save <= reg_wdata & scaler_ctrl_pkg::PS_WRITE_MASK;
    end
  end

  // ************************************************************
  // Task register sets
  // ************************************************************
  // Two separate sets.
  task_reg_set u_set_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(reg_wr && hit(reg_addr, scaler_ctrl_pkg::ADDR_TASK_A)),
    .wr_data(reg_wdata),
    .rd_data(task_a_rd),
    .fields(fields_a)
  );

  task_reg_set u_set_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(reg_wr && hit(reg_addr, scaler_ctrl_pkg::ADDR_TASK_B)),
    .wr_data(reg_wdata),
    .rd_data(task_b_rd),
    .fields(fields_b)
  );

  // ************************************************************
  // Power control outputs
  // ************************************************************
  // Scaler may run only when awake, released, and its sources survive decoder sleep.
  always_comb begin
    scaler_ok = !power_save[scaler_ctrl_pkg::PS_DECODER_SLEEP] ||
                (scaler_source_is_expansion && image_clock_is_expansion);
  end

  always_comb begin
    power_out.first_channel_active = power_save[scaler_ctrl_pkg::PS_FIRST_CH];
    power_out.second_channel_active = power_save[scaler_ctrl_pkg::PS_SECOND_CH];
    power_out.scaler_hold_idle = !power_save[scaler_ctrl_pkg::PS_SOFT_RST];
    power_out.decoder_power_down = power_save[scaler_ctrl_pkg::PS_DECODER_SLEEP];
    power_out.scaler_power_down = power_save[scaler_ctrl_pkg::PS_SCALER_SLEEP];
    power_out.scaler_running = !power_save[scaler_ctrl_pkg::PS_SCALER_SLEEP] &&
                               power_save[scaler_ctrl_pkg::PS_SOFT_RST] && scaler_ok;
    power_out.image_port_out_enable = power_out.scaler_running;
    power_out.audio_clock_power_down = power_save[scaler_ctrl_pkg::PS_AUDIO_SLEEP];
    power_out.audio_clock_out_enable = !power_save[scaler_ctrl_pkg::PS_AUDIO_SLEEP];
  end

  // ************************************************************
  // Task sequencer
  // ************************************************************
  // The set in use is the one latched at request time, so a host write to
  // the other set mid-task cannot disturb the running task.
  assign sel = using_b ? fields_b : fields_a;

  // Next-state logic: skip the programmed number of fields, then run.
  always_comb begin
    next_state = state;
    next_toggle = task_toggle;
    case (state)
      scaler_ctrl_pkg::TS_IDLE: begin
        if (task_request) begin
          if ((task_use_set_b ? fields_b.field_skip_count : fields_a.field_skip_count) ==
              scaler_ctrl_pkg::SKIP_ZERO) begin
            next_state = scaler_ctrl_pkg::TS_RUN;
            next_toggle = !task_toggle;
          end else begin
            next_state = scaler_ctrl_pkg::TS_SKIP;
          end
        end
      end
      scaler_ctrl_pkg::TS_SKIP: begin
        if (field_start && skip_left == 3'h1) begin
          next_state = scaler_ctrl_pkg::TS_RUN;
          next_toggle = !task_toggle;
        end
      end
      scaler_ctrl_pkg::TS_RUN: begin
        // The task lasts one field, then the sequencer waits for the next request.
        if (field_start) begin
          next_state = scaler_ctrl_pkg::TS_IDLE;
        end
      end
      default: begin
        next_state = scaler_ctrl_pkg::TS_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= scaler_ctrl_pkg::TS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Toggle bit flips once per activation; task_flag is the inverse of polarity.
  // Toggle on activation.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      task_toggle <= 1'b0;
    end else begin
      task_toggle <= next_toggle;
    end
  end

  // Skip counter and set selection, loaded at request.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      skip_left <= scaler_ctrl_pkg::SKIP_ZERO;
      using_b <= 1'b0;
    end else if (state == scaler_ctrl_pkg::TS_IDLE && task_request) begin
      using_b <= task_use_set_b;
      skip_left <= task_use_set_b ? fields_b.field_skip_count : fields_a.field_skip_count;
    end else if (state == scaler_ctrl_pkg::TS_SKIP && field_start) begin
      skip_left <= skip_left - 3'h1;
    end
  end

  // ************************************************************
  // Field id and code bit outputs
  // ************************************************************
  // Registered so the outputs are clean flip-flop levels.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      output_field_id <= 1'b0;
      code_bit_d7 <= 1'b1;
      task_flag <= 1'b1;
    end else begin
      output_field_id <= sel.output_field_id_select ? task_toggle : status_in.input_field_id;
      code_bit_d7 <= !sel.task_flag_polarity;
      task_flag <= !sel.task_flag_polarity;
    end
  end

  assign task_active = (state == scaler_ctrl_pkg::TS_RUN);

  // ************************************************************
  // Status byte and read mux
  // ************************************************************
  // Status is built from live inputs with no capture stage, so a read sees
  // whatever holds at that instant; the price is that a flag may change mid-read.
  always_comb begin
    status_byte = 8'h00;
    status_byte[scaler_ctrl_pkg::ST_EXPANSION_TRISTATE_PIN] = status_in.expansion_tristate_pin;
    status_byte[scaler_ctrl_pkg::ST_IMAGE_TRISTATE_PIN] = status_in.image_tristate_pin;
    status_byte[scaler_ctrl_pkg::ST_FIFO_FILL] = status_in.fifo_almost_filled;
    status_byte[scaler_ctrl_pkg::ST_FIFO_OVF] = status_in.fifo_overflow_flag;
    status_byte[scaler_ctrl_pkg::ST_ECHO] = power_save[scaler_ctrl_pkg::PS_MARKER];
    status_byte[scaler_ctrl_pkg::ST_FMT_ERR] = status_in.formatter_error;
    status_byte[scaler_ctrl_pkg::ST_IN_FID] = status_in.input_field_id;
    status_byte[scaler_ctrl_pkg::ST_OUT_FID] = output_field_id;
  end

  // Read mux; unmapped subaddresses and idle cycles read as zero.
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_rd) begin
      if (hit(reg_addr, scaler_ctrl_pkg::ADDR_POWER_SAVE)) begin
        reg_rdata = power_save;
      end else if (hit(reg_addr, scaler_ctrl_pkg::ADDR_STATUS)) begin
        reg_rdata = status_byte;
      end else if (hit(reg_addr, scaler_ctrl_pkg::ADDR_TASK_A)) begin
        reg_rdata = task_a_rd;
      end else if (hit(reg_addr, scaler_ctrl_pkg::ADDR_TASK_B)) begin
        reg_rdata = task_b_rd;
      end
    end
  end

endmodule

/* File: tb/spst_checker_assertions.sv */
// Purpose: Port checks for the power, status and task control block.
// Assumes: One clock, clk_sys, with async active-low rst_n.
// Notes: Shadows mirror host writes, so a lost or misplaced write shows up.
module spst_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire scaler_ctrl_pkg::status_in_t status_in,
  input wire logic scaler_source_is_expansion,
  input wire logic image_clock_is_expansion,
  input wire logic field_start,
  input wire logic task_request,
  input wire logic task_use_set_b,
  input wire scaler_ctrl_pkg::power_out_t power_out,
  input wire logic output_field_id,
  input wire logic code_bit_d7,
  input wire logic task_flag,
  input wire logic task_active
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********
  // Shadow state
  // ********
  logic [7:0] ps; // Power-save mirror.
  logic [4:0] sa; // Set A upper fields.
  logic [4:0] sb; // Set B upper fields.
  logic lb; // Set B latched by the last request.
  logic up; // One edge has passed since reset.
  wire logic rd_st = reg_rd && reg_addr == scaler_ctrl_pkg::ADDR_STATUS;
  wire logic rd_ps = reg_rd && reg_addr == scaler_ctrl_pkg::ADDR_POWER_SAVE;
  wire logic [2:0] skp = task_use_set_b ? sb[2:0] : sa[2:0];
  wire logic sel = lb ? sb[3] : sa[3];
  wire logic run_ok = ps[5] && !ps[1] && (!ps[0] || (scaler_source_is_expansion && image_clock_is_expansion));

  // Mirror accepted writes; the reserved bit is dropped as the design must.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ps <= 8'h00;
      sa <= 5'h00;
      sb <= 5'h00;
      lb <= 1'b0;
      up <= 1'b0;
    end else begin
      up <= 1'b1;
      if (reg_wr && reg_addr == scaler_ctrl_pkg::ADDR_POWER_SAVE) begin
        ps <= reg_wdata & scaler_ctrl_pkg::PS_WRITE_MASK;
      end
      if (reg_wr && reg_addr == scaler_ctrl_pkg::ADDR_TASK_A) begin
        sa <= reg_wdata[7:3];
      end
      if (reg_wr && reg_addr == scaler_ctrl_pkg::ADDR_TASK_B) begin
        sb <= reg_wdata[7:3];
      end
      if (task_request && !task_active) begin
        lb <= task_use_set_b;
      end
    end
  end

  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_echo; rd_st |-> reg_rdata[3] == ps[4]; endproperty
  a_echo: assert property (p_echo) else $error("echo bit wrong");
  property p_live; rd_st |-> {reg_rdata[7:4], reg_rdata[2:1]} == status_in; endproperty
  a_live: assert property (p_live) else $error("status not live");
  property p_rsv; rd_ps |-> reg_rdata == ps; endproperty
  a_rsv: assert property (p_rsv) else $error("power-save readback wrong");
  property p_chan; {power_out.first_channel_active, power_out.second_channel_active} == {ps[6], ps[7]}; endproperty
  a_chan: assert property (p_chan) else $error("channel enable wrong");
  property p_idle; power_out.scaler_hold_idle != ps[5]; endproperty
  a_idle: assert property (p_idle) else $error("scaler idle hold wrong");
  property p_slp; {power_out.scaler_power_down, power_out.image_port_out_enable,
    power_out.audio_clock_power_down, power_out.audio_clock_out_enable} == {ps[1], run_ok, ps[3], !ps[3]}; endproperty
  a_slp: assert property (p_slp) else $error("sleep controls wrong");
  property p_run; power_out.decoder_power_down == ps[0] && power_out.scaler_running == run_ok; endproperty
  a_run: assert property (p_run) else $error("decoder sleep wrong");
  property p_flag; code_bit_d7 == task_flag; endproperty
  a_flag: assert property (p_flag) else $error("code bit and flag differ");
  property p_skp0; task_request && !task_active && skp == scaler_ctrl_pkg::SKIP_ZERO |=> task_active; endproperty
  a_skp0: assert property (p_skp0) else $error("direct task did not start");
  property p_skpn; task_request && skp != scaler_ctrl_pkg::SKIP_ZERO |=> !task_active; endproperty
  a_skpn: assert property (p_skpn) else $error("task started early");
  property p_end; task_active && field_start |=> !task_active; endproperty
  a_end: assert property (p_end) else $error("task ran past one field");
  property p_fid; up && !sel && !$past(sel) |-> output_field_id == $past(status_in.input_field_id); endproperty
  a_fid: assert property (p_fid) else $error("output field id not input");
endmodule

bind scaler_power_status_task_ctrl spst_checker u_chk (.*);

/* File: tb/scaler_host_model.sv */
// Purpose: Host side of the subaddressed register bus, one byte per access.
// Assumes: Accesses begin on a falling edge after reset release.
// Notes: Released data lines invert so a stale byte is never mistaken.
module scaler_host_model (
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bus is idle from time zero.
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // One strobe cycle; the read result is taken at the rising edge inside it.
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = ~d;
  endtask
endmodule

/* File: tb/scaler_power_status_task_ctrl_tb.sv */
// Purpose: Self-checking bench for power, status and task control.
// Assumes: Toggle flag starts at 0 after reset.
// Notes: Expected values queue up; a monitor compares them as results appear.
module scaler_power_status_task_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst_n, reg_wr, reg_rd, field_start, task_request, task_use_set_b;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ps, v;
  scaler_ctrl_pkg::status_in_t status_in;
  scaler_ctrl_pkg::power_out_t power_out;
  logic scaler_source_is_expansion, image_clock_is_expansion, output_field_id, code_bit_d7, task_flag;
  logic task_active, probe, tog;
  logic [15:0] q[$]; // Expected results, oldest first.
  int err_total, n_tests, i, k;

  scaler_power_status_task_ctrl dut (.clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .status_in, .scaler_source_is_expansion, .image_clock_is_expansion, .field_start, .task_request,
    .task_use_set_b, .power_out, .output_field_id, .code_bit_d7, .task_flag, .task_active);
  scaler_host_model host (.clk_sys, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);

  // Free-running 100 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Take the oldest note whenever a read or a probe shows a result.
  always @(posedge clk_sys) begin
    if (reg_rd === 1'b1 || probe === 1'b1) begin
      chk(reg_rd ? {8'h00, reg_rdata} : {3'h0, power_out, task_active, code_bit_d7, task_flag, output_field_id},
        q.pop_front());
    end
  end

  // Expected power controls from the written byte and the source selects.
  function automatic logic [8:0] epw(input logic [7:0] p, input logic s, input logic c);
    // Image port output follows the running scaler, so both bits share one term.
    epw = {p[6], p[7], !p[5], p[0], p[1], {2{p[5] & !p[1] & (!p[0] | (s & c))}}, p[3], !p[3]};
  endfunction

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back({8'h00, e});
    host.access(a, 8'h00, 1'b0);
  endtask

  // Probe the outputs: active, code bit, flag and field id after the power bits.
  task automatic pr(input logic [3:0] e);
    q.push_back({3'h0, epw(ps, scaler_source_is_expansion, image_clock_is_expansion), e});
    @(negedge clk_sys);
    probe = 1'b1;
    @(negedge clk_sys);
    probe = 1'b0;
  endtask

  task automatic pulse();
    @(negedge clk_sys);
    field_start = 1'b1;
    @(negedge clk_sys);
    field_start = 1'b0;
  endtask

  // Start a task and count its skipped fields; a field id select of 1 shows the toggle.
  task automatic run(input logic b, input int n, input logic pol, input logic sel);
    @(negedge clk_sys);
    task_request = 1'b1;
    task_use_set_b = b;
    @(negedge clk_sys);
    task_request = 1'b0;
    for (k = 0; k < n; k++) begin
      if (k == n - 1) begin
        pr({1'b0, !pol, !pol, sel ? tog : status_in[0]});
      end
      pulse();
    end
    tog = ~tog;
    pr({1'b1, !pol, !pol, sel ? tog : status_in[0]});
    pulse();
    pr({1'b0, !pol, !pol, sel ? tog : status_in[0]});
  endtask

  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cut a hang short well past the expected run length.
  initial begin
    #200us;
    err_total++;
    complete_run();
  end

  // Main sequence.
  initial begin
    {rst_n, field_start, task_request, task_use_set_b, probe, tog, scaler_source_is_expansion} = 7'h00;
    {image_clock_is_expansion, status_in, ps, err_total, n_tests} = '0;
    v = 8'($urandom(55));
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    rd(scaler_ctrl_pkg::ADDR_POWER_SAVE, scaler_ctrl_pkg::PS_RESET);
    rd(scaler_ctrl_pkg::ADDR_TASK_B, scaler_ctrl_pkg::TK_RESET);
    pr(4'b0110);
    for (i = 0; i < 8; i++) begin
      status_in = 6'($urandom);
      rd(scaler_ctrl_pkg::ADDR_STATUS, {status_in[5:2], ps[4], status_in[1:0], status_in[0]});
    end
    for (i = 0; i < 12; i++) begin
      v = (i == 0) ? 8'h21 : 8'($urandom);
      scaler_source_is_expansion = (i == 0) | 1'($urandom);
      image_clock_is_expansion = (i == 0) | 1'($urandom);
      host.access(scaler_ctrl_pkg::ADDR_POWER_SAVE, v, 1'b1);
      ps = v & 8'hFB;
      rd(scaler_ctrl_pkg::ADDR_POWER_SAVE, ps);
      rd(scaler_ctrl_pkg::ADDR_STATUS, {status_in[5:2], ps[4], status_in[1:0], status_in[0]});
      pr({1'b0, 2'b11, status_in[0]});
    end
    host.access(scaler_ctrl_pkg::ADDR_STATUS, 8'hFF, 1'b1);
    host.access(8'h55, 8'hFF, 1'b1);
    rd(8'h55, 8'h00);
    host.access(scaler_ctrl_pkg::ADDR_TASK_A, 8'hD0, 1'b1);
    host.access(scaler_ctrl_pkg::ADDR_TASK_B, 8'h07, 1'b1);
    rd(scaler_ctrl_pkg::ADDR_TASK_B, 8'h00);
    rd(scaler_ctrl_pkg::ADDR_TASK_A, 8'hD0);
    run(1'b0, 2, 1'b1, 1'b1);
    run(1'b1, 0, 1'b0, 1'b0);
    host.access(scaler_ctrl_pkg::ADDR_TASK_A, 8'hF8, 1'b1);
    run(1'b0, 7, 1'b1, 1'b1);
    complete_run();
  end
endmodule
